//--- verification/drive_model.sv
// drive partner: answers seeks, shows one sector id, offers byte slots
// assumes the bench clock; all outputs move at the falling edge
module drive_model (
  // clock, reset, pacing
  input wire logic clock,
  input wire logic rst,
  input wire logic slow,
  // decoder side
  input wire logic executing,
  input wire logic seek_req,
  output logic seek_done,
  output logic disk_strobe,
  output logic [7:0] disk_rd_data,
  output logic id_valid,
  output logic id_head
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt; // cycles since run start or seek request
  initial {seek_done, disk_strobe, disk_rd_data, id_valid, id_head} = '0;
  // slots start inside the head load wait, which must ignore them; data lines churn when idle
  always @(negedge clock) begin
    if (rst || executing !== 1'b1 || seek_req === 1'b1) cnt <= 0;
    else cnt <= cnt + 1;
    seek_done <= (cnt == 3);
    id_valid <= (cnt == 10);
    id_head <= 1'($urandom);
    disk_strobe <= cnt > 20 && (!slow || cnt[0]);
    disk_rd_data <= cnt > 20 ? 8'($urandom) : ~disk_rd_data;
  end
endmodule : drive_model

//--- verification/floppy_cmd_param_decode_chk.sv
// checker: timing relations seen at the decoder ports
// assumes a bind onto the decoder top; one clock domain
module floppy_cmd_param_decode_chk #(
  parameter int LOAD_UNIT = 4,
  parameter int UNLOAD_UNIT = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // watched ports
  input wire logic param_we,
  input wire logic [3:0] param_slot,
  input wire logic [7:0] param_data,
  input wire logic exec_start,
  input wire logic cmd_has_cylinder,
  input wire logic disk_strobe,
  input wire logic id_valid,
  input wire logic seek_req,
  input wire logic head_loaded,
  input wire logic executing,
  input wire logic exec_done,
  input wire logic host_rd_valid,
  input wire logic crc_valid,
  input wire logic queue_enabled,
  input wire logic [7:0] gap2_len,
  input wire logic [7:0] gap3_len,
  input wire logic id_match
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic wr_ok; // a parameter write that is taken
  assign wr_ok = param_we && !executing;
  property p_queue; wr_ok && param_slot == 4'h6 |=> queue_enabled == !$past(param_data[5]); endproperty
  a_queue: assert property (p_queue) else $error("queue enable wrong");
  property p_gap3; wr_ok && param_slot == 4'h4 |=> gap3_len == $past(param_data); endproperty
  a_gap3: assert property (p_gap3) else $error("gap3 wrong");
  property p_gap2;
    wr_ok && param_slot == 4'h8 |-> ##2 gap2_len == (&$past(param_data[1:0], 2) ? 8'h29 : 8'h16);
  endproperty
  a_gap2: assert property (p_gap2) else $error("gap2 wrong");
  property p_frz; executing && $past(executing) |-> $stable(gap3_len) && $stable(queue_enabled); endproperty
  a_frz: assert property (p_frz) else $error("param changed in run");
  property p_start; exec_start && !executing |=> executing; endproperty
  a_start: assert property (p_start) else $error("run not started");
  property p_seek; seek_req |-> executing && $past(exec_start && cmd_has_cylinder && !executing); endproperty
  a_seek: assert property (p_seek) else $error("stray seek");
  property p_hrv; host_rd_valid |-> head_loaded && $past(disk_strobe && executing); endproperty
  a_hrv: assert property (p_hrv) else $error("host byte without slot");
  property p_done; exec_done |-> crc_valid && !executing && $past(executing); endproperty
  a_done: assert property (p_done) else $error("bad run end");
  property p_id; id_match |-> $past(id_valid); endproperty
  a_id: assert property (p_id) else $error("stray id match");
  c_done: cover property (exec_done);
  c_seek: cover property (seek_req);
  c_id: cover property (id_match);
endmodule : floppy_cmd_param_decode_chk
bind floppy_cmd_param_decode floppy_cmd_param_decode_chk #(
  .LOAD_UNIT(LOAD_UNIT),
  .UNLOAD_UNIT(UNLOAD_UNIT)
) u_chk (.*);

//--- verification/testbench.sv
// bench: reference model of byte slots, crc and parameter decode
// assumes drive_model and the checker bind; inputs move at falling edge
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst = 1, param_we = 0, exec_start = 0, slow = 0;
  logic cmd_read = 0, cmd_write = 0, cmd_verify = 0, cmd_has_cylinder = 0, hd, ihd, ichk, wchk;
  logic [3:0] param_slot = 0;
  logic [7:0] param_data = 0, host_wr_data = 0, gd, b, wexp;
  logic [15:0] crc, ecrc;
  wire logic seek_done, disk_strobe, id_valid, id_head, seek_req, head_loaded, executing;
  wire logic exec_done, host_rd_valid, crc_valid, id_match, queue_enabled;
  wire logic [7:0] disk_rd_data, sector_number, host_rd_data, disk_wr_data, gap2_len, gap3_len;
  wire logic [15:0] sector_crc;
  int num_errors = 0, compares = 0, idx, hp, len, nh, nc, nsk;
  int ne, sk, ph, lw, lt, ms; // sectors due, seek due, model phase, load wait count, load wait length, sectors seen
  logic [7:0] q[$]; // bytes owed to the host
  always #50 clock = ~clock;
  floppy_cmd_param_decode #(.LOAD_UNIT(4), .UNLOAD_UNIT(8)) u_floppy_cmd_param_decode (.*);
  drive_model u_drive_model (.*);
  // one comparison, counted
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  // crc ccitt step, msb first
  function automatic logic [15:0] cf(logic [15:0] c, logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction : cf
  // one parameter byte
  task automatic wp(input logic [3:0] s, input logic [7:0] d);
    param_we = 1;
    param_slot = s;
    param_data = d;
    @(negedge clock) param_we = 0;
    // one idle edge so that a following call never re-raises the strobe in one step
    @(negedge clock);
  endtask : wp
  // run phases (0 idle, 1 seek, 2 head load wait, 3 slots); slots count only in phase 3
  always @(posedge clock) begin
    ichk = id_valid;
    ihd = id_head;
    wchk = 0;
    case (ph)
      0: if (exec_start === 1'b1) ph = sk ? 1 : 2;
      1: if (seek_done === 1'b1) ph = 2;
      2: begin
        if (lw >= lt) ph = 3;
        else lw++;
      end
      default: if (disk_strobe === 1'b1) begin
        b = cmd_write ? (idx < hp ? host_wr_data : 8'h00) : disk_rd_data;
        crc = cf(crc, b);
        wexp = b;
        wchk = cmd_write;
        if (cmd_read && idx < hp) q.push_back(b);
        if (++idx == len) begin
          idx = 0;
          ecrc = crc;
          crc = 16'hFFFF;
          if (++ms == ne) ph = 0;
        end
      end
    endcase
  end
  // compare settled outputs, then change host data
  always @(negedge clock) begin
    if (host_rd_valid === 1'b1) begin
      nh++;
      chk(q.size() > 0 && host_rd_data === q.pop_front(), "host byte");
    end
    if (crc_valid === 1'b1) begin
      nc++;
      chk(sector_crc === ecrc, "crc");
      chk(sector_number === 8'(nc < ne ? nc + 1 : nc), "sector");
    end
    if (wchk) chk(disk_wr_data === wexp, "write byte");
    if (ichk) chk(id_match === (ihd === hd), "id match");
    if (seek_req === 1'b1) nsk++;
    host_wr_data = 8'($urandom);
  end
  // one command: parameters, run, then counts and unload
  task automatic run(input logic r, w, v, c, input logic [7:0] sz, sh, lst, sp, input int ns, es);
    int t;
    wp(4'h2, sz);
    wp(4'h5, sh);
    wp(4'h1, 8'h01);
    wp(4'h3, lst);
    wp(4'h7, sp);
    hd = 1'($urandom);
    wp(4'h0, {7'h00, hd});
    len = 128 << sz;
    hp = sz == 0 ? sh : len;
    ne = ns;
    sk = es;
    lt = 4 * sp[7:1];
    {lw, ms, ph} = {32'd0, 32'd0, 32'd0};
    {idx, nh, nc, nsk, crc} = {32'd0, 32'd0, 32'd0, 32'd0, 16'hFFFF};
    {cmd_read, cmd_write, cmd_verify, cmd_has_cylinder, exec_start} = {r, w, v, c, 1'b1};
    @(negedge clock) exec_start = 0;
    wp(4'h4, ~gd);
    t = 0;
    while (exec_done !== 1'b1 && t < 5000) begin
      @(negedge clock);
      t++;
    end
    @(negedge clock);
    chk(t < 5000 && gap3_len === gd, "run end");
    chk(nc == ns && nh == (r ? ns * hp : 0), "counts");
    chk(nsk == es, "seek count");
    t = 0;
    while (head_loaded !== 1'b0 && t < 40) begin
      @(negedge clock);
      t++;
    end
    chk(t > 4 && t < 40, "unload");
    {cmd_read, cmd_write, cmd_verify, cmd_has_cylinder} = 4'h0;
  endtask : run
  // verdict and end of run
  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // cut a hang short
  initial begin
    #1ms;
    num_errors++;
    print_verdict();
  end
  // main sequence
  initial begin
    void'($urandom(73818));
    repeat (4) @(posedge clock);
    @(negedge clock) rst = 0;
    chk(queue_enabled === 1'b0 && gap2_len === 8'h16, "reset values");
    wp(4'h6, 8'h40);
    chk(queue_enabled === 1'b1, "queue on");
    wp(4'h8, 8'h03);
    @(negedge clock);
    chk(gap2_len === 8'h29, "gap2 perp");
    wp(4'h8, 8'h01);
    @(negedge clock);
    chk(gap2_len === 8'h16, "gap2 std");
    for (int i = 0; i < 3; i++) begin
      gd = 8'($urandom);
      wp(4'h4, gd);
      chk(gap3_len === gd, "gap3");
    end
    run(1, 0, 0, 1, 8'h00, 8'h02, 8'h01, 8'h12, 1, 1);
    run(0, 1, 0, 0, 8'h00, 8'h03, 8'h01, 8'h12, 1, 0);
    slow = 1;
    run(1, 0, 0, 1, 8'h01, 8'hFF, 8'h02, 8'h12, 2, 1);
    wp(4'h6, 8'h20);
    chk(queue_enabled === 1'b0, "queue off");
    run(0, 0, 1, 1, 8'h00, 8'h02, 8'h09, 8'h13, 2, 0);
    print_verdict();
  end
endmodule : testbench

//--- verilog/cmd_param_pkg.sv
// constants for the floppy command parameter decoder: parameter byte slots,
// sector geometry, gap figures, head timing units, crc figures, states.
// assumes one 10 MHz controller clock shared with the command decoder.
//
// Functional notes
// - size code zero: 128 bytes, short length counts
// - read: surplus sector bytes read, not passed
// - write: surplus sector bytes written as zero
// - crc covers every physical sector byte
// - verify override: short length is sector count
// - queue enable low, off after reset
// - implied seek before cylinder commands when enabled
// - last sector number ends multi-sector run
// - perpendicular mode gap 2 from gap parameter
// - spacing length gives gap 3 size
// - head side matched against sector id head
// - wait head load interval before transfer
// - unload head after unload interval elapses
// - sector size 128 shifted by size code
package cmd_param_pkg;
  // parameter byte slots written during the command phase
  localparam logic [3:0] SLOT_HEAD = 4'h0;
  localparam logic [3:0] SLOT_SECTOR = 4'h1;
  localparam logic [3:0] SLOT_SIZE = 4'h2;
  localparam logic [3:0] SLOT_LAST = 4'h3;
  localparam logic [3:0] SLOT_SPACING = 4'h4;
  localparam logic [3:0] SLOT_SHORT = 4'h5;
  localparam logic [3:0] SLOT_CONFIG = 4'h6;
  localparam logic [3:0] SLOT_SPECIFY = 4'h7;
  localparam logic [3:0] SLOT_PERP = 4'h8;
  // bit positions inside the configuration and mode bytes
  localparam int CFG_QUEUE_BIT = 5;
  localparam int CFG_SEEK_BIT = 6;
  localparam int PERP_GAP_BIT = 1;
  localparam int PERP_MODE_BIT = 0;
  localparam int VERIFY_COUNT_BIT = 0;
  // reset values
  localparam logic QUEUE_LOW_RESET = 1'b1;
  localparam logic [7:0] SHORT_RESET = 8'hFF;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // sector geometry
  localparam logic [14:0] BASE_SECTOR = 15'h0080;
  localparam logic [2:0] MAX_SIZE_CODE = 3'h7;
  // gap 2 lengths in bytes, standard and perpendicular
  localparam logic [7:0] GAP2_STD = 8'h16;
  localparam logic [7:0] GAP2_PERP = 8'h29;
  // head timing units in microseconds and cycles at 10 MHz
  localparam int CLOCK_MHZ = 10;
  localparam int LOAD_UNIT_US = 2000;
  localparam int UNLOAD_UNIT_US = 16000;
  localparam int LOAD_UNIT_CYCLES = LOAD_UNIT_US * CLOCK_MHZ;
  localparam int UNLOAD_UNIT_CYCLES = UNLOAD_UNIT_US * CLOCK_MHZ;
  // crc ccitt
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEEK = 2'b01,
    ST_LOAD = 2'b10,
    ST_XFER = 2'b11
  } seq_state_t;
endpackage : cmd_param_pkg

//--- verilog/floppy_cmd_param_decode.sv
// floppy command parameter decoder: latches command phase parameter bytes and
// sequences the execution phase (seek, head load, byte slots, crc, unload).
// assumes all inputs come from logic on the same clock; one byte slot per strobe.
module floppy_cmd_param_decode #(
  parameter int LOAD_UNIT = cmd_param_pkg::LOAD_UNIT_CYCLES,
  parameter int UNLOAD_UNIT = cmd_param_pkg::UNLOAD_UNIT_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // command phase parameter bytes
  input wire logic param_we,
  input wire logic [3:0] param_slot,
  input wire logic [7:0] param_data,
  // command kind and execution control
  input wire logic exec_start,
  input wire logic cmd_read,
  input wire logic cmd_write,
  input wire logic cmd_verify,
  input wire logic cmd_has_cylinder,
  input wire logic seek_done,
  // drive side byte slots and sector id
  input wire logic disk_strobe,
  input wire logic [7:0] disk_rd_data,
  input wire logic id_valid,
  input wire logic id_head,
  // host side write data
  input wire logic [7:0] host_wr_data,
  // sequencing outputs
  output logic seek_req,
  output logic head_loaded,
  output logic executing,
  output logic exec_done,
  output logic [7:0] sector_number,
  // data outputs
  output logic host_rd_valid,
  output logic [7:0] host_rd_data,
  output logic [7:0] disk_wr_data,
  output logic [15:0] sector_crc,
  output logic crc_valid,
  // decoded parameters
  output logic id_match,
  output logic queue_enabled,
  output logic [7:0] gap2_len,
  output logic [7:0] gap3_len
);
  // latched parameter bytes
  logic [7:0] head_q, first_q, size_q, last_q, spacing_q, short_q, cfg_q, spec_q, perp_q;
  // command kind captured at execution start
  logic rd_q, wr_q, vf_q;
  // sequencer state and counters
  cmd_param_pkg::seq_state_t state_q;
  logic [14:0] byte_idx_q;
  logic [7:0] sect_cnt_q;
  logic [15:0] crc_q;
  logic [23:0] load_cnt_q;
  logic [27:0] unload_cnt_q;
  logic unload_pend_q;
  // outputs held in flops
  logic seek_req_q, loaded_q, exec_done_q, rd_valid_q, crc_valid_q, match_q;
  logic exec_q; // execution phase flag, mirrors state_q != ST_IDLE from a flop
  logic [7:0] sector_q, rd_data_q, wr_data_q, gap2_q;
  logic [15:0] crc_out_q;

  // one crc-ccitt step over a byte, msb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ cmd_param_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  // decoded geometry
  logic [2:0] code;
  logic [14:0] phys_len, host_len;
  logic last_byte, last_sector, in_host_part;
  logic [7:0] slot_byte;
  always_comb begin
    // codes above the largest valid one clamp to it
    code = (size_q > {5'h00, cmd_param_pkg::MAX_SIZE_CODE}) ? cmd_param_pkg::MAX_SIZE_CODE
                                                           : size_q[2:0];
    phys_len = cmd_param_pkg::BASE_SECTOR << code;
    // short length only counts with size code zero; otherwise ignored
    host_len = (code == 3'h0) ? {7'h00, short_q} : phys_len;
    in_host_part = byte_idx_q < host_len;
    last_byte = byte_idx_q == (phys_len - 15'h0001);
    // verify with count override ends on sector count, else on last sector
    if (vf_q && spec_q[cmd_param_pkg::VERIFY_COUNT_BIT]) begin
      last_sector = (sect_cnt_q + 8'h01) >= short_q;
    end else begin
      last_sector = sector_q == last_q;
    end
    // surplus bytes of a write go to disk as zero
    slot_byte = wr_q ? (in_host_part ? host_wr_data : 8'h00) : disk_rd_data;
  end

  // parameter latch, blocked while executing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      head_q <= cmd_param_pkg::BYTE_RESET;
      first_q <= cmd_param_pkg::BYTE_RESET;
      size_q <= cmd_param_pkg::BYTE_RESET;
      last_q <= cmd_param_pkg::BYTE_RESET;
      spacing_q <= cmd_param_pkg::BYTE_RESET;
      short_q <= cmd_param_pkg::SHORT_RESET;
      cfg_q <= cmd_param_pkg::BYTE_RESET;
      spec_q <= cmd_param_pkg::BYTE_RESET;
      perp_q <= cmd_param_pkg::BYTE_RESET;
    end else if (param_we && state_q == cmd_param_pkg::ST_IDLE) begin
      case (param_slot)
        cmd_param_pkg::SLOT_HEAD: head_q <= param_data;
        cmd_param_pkg::SLOT_SECTOR: first_q <= param_data;
        cmd_param_pkg::SLOT_SIZE: size_q <= param_data;
        cmd_param_pkg::SLOT_LAST: last_q <= param_data;
        cmd_param_pkg::SLOT_SPACING: spacing_q <= param_data;
        cmd_param_pkg::SLOT_SHORT: short_q <= param_data;
        cmd_param_pkg::SLOT_CONFIG: cfg_q <= param_data;
        cmd_param_pkg::SLOT_SPECIFY: spec_q <= param_data;
        cmd_param_pkg::SLOT_PERP: perp_q <= param_data;
        default: ; // unknown slots are ignored
      endcase
    end
  end

  // queue enable bit is active low; the reset default leaves the queue off
  // the flop holds the inverted sense so the output needs no gate after it
  logic queue_on_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      queue_on_q <= ~cmd_param_pkg::QUEUE_LOW_RESET;
    end else if (param_we && state_q == cmd_param_pkg::ST_IDLE &&
                 param_slot == cmd_param_pkg::SLOT_CONFIG) begin
      queue_on_q <= ~param_data[cmd_param_pkg::CFG_QUEUE_BIT];
    end
  end

  // gap lengths and head id comparison
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gap2_q <= cmd_param_pkg::GAP2_STD;
      match_q <= 1'b0;
    end else begin
      if (perp_q[cmd_param_pkg::PERP_MODE_BIT] && perp_q[cmd_param_pkg::PERP_GAP_BIT]) begin
        gap2_q <= cmd_param_pkg::GAP2_PERP;
      end else begin
        gap2_q <= cmd_param_pkg::GAP2_STD;
      end
      // one-cycle pulse when an id field shows the selected side
      match_q <= id_valid && (id_head == head_q[0]);
    end
  end

  // execution sequencer: seek, head load, byte slots, sector stepping
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= cmd_param_pkg::ST_IDLE;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      vf_q <= 1'b0;
      exec_q <= 1'b0;
      seek_req_q <= 1'b0;
      exec_done_q <= 1'b0;
      load_cnt_q <= 24'h000000;
      byte_idx_q <= 15'h0000;
      sect_cnt_q <= 8'h00;
      sector_q <= 8'h00;
      crc_q <= cmd_param_pkg::CRC_INIT;
      crc_out_q <= 16'h0000;
      crc_valid_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      seek_req_q <= 1'b0;
      exec_done_q <= 1'b0;
      crc_valid_q <= 1'b0;
      rd_valid_q <= 1'b0;
      case (state_q)
        cmd_param_pkg::ST_IDLE: begin
          if (exec_start) begin
            rd_q <= cmd_read;
            wr_q <= cmd_write;
            vf_q <= cmd_verify;
            exec_q <= 1'b1;
            sector_q <= first_q;
            sect_cnt_q <= 8'h00;
            byte_idx_q <= 15'h0000;
            crc_q <= cmd_param_pkg::CRC_INIT;
            load_cnt_q <= 24'h000000;
            // implied seek only for commands carrying a cylinder
            if (cfg_q[cmd_param_pkg::CFG_SEEK_BIT] && cmd_has_cylinder &&
                (cmd_read || cmd_write || cmd_verify)) begin
              seek_req_q <= 1'b1;
              state_q <= cmd_param_pkg::ST_SEEK;
            end else begin
              state_q <= cmd_param_pkg::ST_LOAD;
            end
          end
        end
        cmd_param_pkg::ST_SEEK: begin
          // wait for the drive side to finish positioning
          if (seek_done) begin
            state_q <= cmd_param_pkg::ST_LOAD;
          end
        end
        cmd_param_pkg::ST_LOAD: begin
          // settle time of head load interval units before any transfer
          if (load_cnt_q >= 24'(LOAD_UNIT) * {17'h00000, spec_q[7:1]}) begin
            state_q <= cmd_param_pkg::ST_XFER;
          end else begin
            load_cnt_q <= load_cnt_q + 24'h000001;
          end
        end
        cmd_param_pkg::ST_XFER: begin
          if (disk_strobe) begin
            wr_data_q <= slot_byte;
            // read bytes past the host part are consumed but not passed on
            rd_valid_q <= rd_q && in_host_part;
            rd_data_q <= disk_rd_data;
            crc_q <= crc_step(crc_q, slot_byte);
            if (last_byte) begin
              byte_idx_q <= 15'h0000;
              crc_out_q <= crc_step(crc_q, slot_byte);
              crc_valid_q <= 1'b1;
              crc_q <= cmd_param_pkg::CRC_INIT;
              sect_cnt_q <= sect_cnt_q + 8'h01;
              if (last_sector) begin
                exec_done_q <= 1'b1;
                exec_q <= 1'b0;
                state_q <= cmd_param_pkg::ST_IDLE;
              end else begin
                sector_q <= sector_q + 8'h01;
              end
            end else begin
              byte_idx_q <= byte_idx_q + 15'h0001;
            end
          end
        end
        default: begin
          state_q <= cmd_param_pkg::ST_IDLE;
          exec_q <= 1'b0;
        end
      endcase
    end
  end

  // head load state and unload timer after execution ends
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      loaded_q <= 1'b0;
      unload_pend_q <= 1'b0;
      unload_cnt_q <= 28'h0000000;
    end else if (state_q != cmd_param_pkg::ST_IDLE) begin
      loaded_q <= (state_q != cmd_param_pkg::ST_SEEK) || loaded_q;
      unload_pend_q <= 1'b0;
      unload_cnt_q <= 28'h0000000;
    end else if (exec_done_q) begin
      unload_pend_q <= 1'b1;
      unload_cnt_q <= 28'h0000000;
    end else if (unload_pend_q) begin
      if (unload_cnt_q >= 28'(UNLOAD_UNIT) * {24'h000000, spec_q[7:4]}) begin
        loaded_q <= 1'b0;
        unload_pend_q <= 1'b0;
      end else begin
        unload_cnt_q <= unload_cnt_q + 28'h0000001;
      end
    end
  end

  // output wiring from flops
  assign seek_req = seek_req_q;
  assign head_loaded = loaded_q;
  assign executing = exec_q;
  assign exec_done = exec_done_q;
  assign sector_number = sector_q;
  assign host_rd_valid = rd_valid_q;
  assign host_rd_data = rd_data_q;
  assign disk_wr_data = wr_data_q;
  assign sector_crc = crc_out_q;
  assign crc_valid = crc_valid_q;
  assign id_match = match_q;
  assign queue_enabled = queue_on_q;
  assign gap2_len = gap2_q;
  assign gap3_len = spacing_q;
endmodule : floppy_cmd_param_decode
